// ---- design/ucp_defines.svh ----
`ifndef UCP_DEFINES_SVH
`define UCP_DEFINES_SVH

// Cell length in octets
`define UCP_CELL_BYTES 53
// Cycles before cell end at which TxClav falls
`define UCP_CLAV_LEAD 4
// Port address width
`define UCP_ADDR_W 5
// Default port addresses of the two paths
`define UCP_FAST_ADDR 5'h00
`define UCP_SLOW_ADDR 5'h01
// Byte counter width
`define UCP_CNT_W 6
`endif

// ---- design/ucp_pkg.sv ----
`default_nettype none
package ucp_pkg;
  // One octet of cell data
  typedef logic [7:0] ucp_byte_t;
  // Cell byte with its path and start-of-cell mark
  typedef struct packed {
    logic path;
    logic soc;
    ucp_byte_t data;
  } ucp_cell_byte_t;
  // Core-side drain machine, one-hot
  typedef enum logic [1:0] {
    UCP_DRN_IDLE = 2'b01,
    UCP_DRN_MOVE = 2'b10
  } ucp_drn_t;
  // All link-domain state
  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] tx_ack_s0, tx_ack_s1, rx_req_s0, rx_req_s1;
    logic ref_s0, ref_s1, ref_d;
    logic [1:0] tx_req, rx_ack;
    logic tx_act, tx_sel, tx_selv;
    logic [5:0] tx_cnt;
    logic rx_act, rx_sel, rx_selv;
    logic [5:0] rx_cnt;
    logic tx_clav, tx_clav_oe, rx_clav, rx_clav_oe;
    logic rx_soc, rx_oe, rx_ref_n;
    ucp_byte_t rx_data;
  } ucp_lk_st_t;
  // All core-domain state
  typedef struct packed {
    logic [1:0] tx_req_s0, tx_req_s1, rx_ack_s0, rx_ack_s1;
    logic tref_s0, tref_s1, tref_d;
    logic [1:0] tx_ack, rx_req;
    ucp_drn_t drn;
    logic drn_p;
    logic [5:0] rd_cnt;
    ucp_cell_byte_t b0, b1;
    logic [1:0] bcnt;
    logic ovld;
    logic [1:0][5:0] wcnt;
    logic [1:0] in_rdy;
    logic ref_tgl, ref_out;
  } ucp_sy_st_t;
endpackage
`default_nettype wire

// ---- design/ucp_phy_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ucp_defines.svh"
module ucp_phy_port #(
  parameter logic [4:0] FAST_ADDR = `UCP_FAST_ADDR,
  parameter logic [4:0] SLOW_ADDR = `UCP_SLOW_ADDR,
  parameter bit OFFICE_END = 1'b1
) (
  // Core clock and control
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Link clock from the far end
  input wire logic link_clk,
  // Transmit pins
  input wire logic tx_enb_n,
  input wire logic tx_soc,
  input wire ucp_pkg::ucp_byte_t tx_data,
  input wire logic [4:0] tx_addr,
  input wire logic tx_ref_n,
  output logic tx_clav,
  output logic tx_clav_oe,
  // Receive pins
  input wire logic rx_enb_n,
  input wire logic [4:0] rx_addr,
  output logic rx_clav,
  output logic rx_clav_oe,
  output logic rx_soc,
  output ucp_pkg::ucp_byte_t rx_data,
  output logic rx_oe,
  output logic rx_ref_n,
  // Received cells toward the core
  output ucp_pkg::ucp_cell_byte_t cell_out,
  output logic cell_out_valid,
  input wire logic cell_out_ready,
  // Cells from the core to send
  input wire ucp_pkg::ucp_cell_byte_t cell_in,
  input wire logic cell_in_valid,
  output logic [1:0] cell_in_ready,
  // Network timing reference, core side
  input wire logic net_ref_in,
  output logic net_ref_out
);
  import ucp_pkg::*;

  localparam int NB = `UCP_CELL_BYTES;
  localparam logic [5:0] LAST = 6'(`UCP_CELL_BYTES - 1);
  localparam logic [5:0] DROP = 6'(`UCP_CELL_BYTES - `UCP_CLAV_LEAD);

  // Cell stores, one per path and direction
  ucp_byte_t tx_mem [0:1][0:NB-1];
  ucp_byte_t rx_mem [0:1][0:NB-1];

  ucp_lk_st_t lk, lk_nxt; // Link-domain state
  ucp_sy_st_t sy, sy_nxt; // Core-domain state
  logic lk_rst;           // Link reset, synchronised
  logic [1:0] tx_full;    // Cell waiting for the core
  logic [1:0] rx_rdy;     // Cell ready for the far end
  logic tx_we, tx_wp;     // Link write to transmit store
  logic [5:0] tx_wa;
  logic rx_we, rx_wp;     // Core write to receive store
  logic [5:0] rx_wa;
  logic [1:0] tx_pa, rx_pa; // Decoded {hit, path}

  // Address decode: which path, if any, is ours
  function automatic logic [1:0] port_of(input logic [4:0] a);
    port_of = (a == FAST_ADDR) ? 2'b10 :
              (a == SLOW_ADDR) ? 2'b11 : 2'b00;
  endfunction

  localparam ucp_sy_st_t SY_RST = '{drn: UCP_DRN_IDLE, default: '0};

  //////////////////////////////////////////////////////////////////////
  // Link domain
  //////////////////////////////////////////////////////////////////////

  assign lk_rst = !lk.rst_s[1];

  // Next link state
  always_comb begin
    lk_nxt = lk;
    tx_we = 1'b0;
    tx_wp = lk.tx_sel;
    tx_wa = lk.tx_cnt;
    tx_pa = port_of(tx_addr);
    rx_pa = port_of(rx_addr);
    tx_full = lk.tx_req ^ lk.tx_ack_s1;
    rx_rdy = lk.rx_req_s1 ^ lk.rx_ack;
    // Crossing stages, first stage feeds only the second
    lk_nxt.tx_ack_s0 = sy.tx_ack;
    lk_nxt.tx_ack_s1 = lk.tx_ack_s0;
    lk_nxt.rx_req_s0 = sy.rx_req;
    lk_nxt.rx_req_s1 = lk.rx_req_s0;
    lk_nxt.ref_s0 = sy.ref_tgl;
    lk_nxt.ref_s1 = lk.ref_s0;
    lk_nxt.ref_d = lk.ref_s1;
    // Transmit select: address taken while enable is high
    if (tx_enb_n) begin
      lk_nxt.tx_selv = tx_pa[1];
      lk_nxt.tx_sel = tx_pa[0];
    end else if (lk.tx_selv) begin
      // Byte taken in the enable-low cycle
      if (tx_soc && !tx_full[lk.tx_sel]) begin
        tx_we = 1'b1;
        tx_wa = '0;
        lk_nxt.tx_act = 1'b1;
        lk_nxt.tx_cnt = 6'h01;
      end else if (lk.tx_act) begin
        tx_we = 1'b1;
        lk_nxt.tx_cnt = lk.tx_cnt + 6'h01;
        // Last byte hands the cell to the core
        if (lk.tx_cnt == LAST) begin
          lk_nxt.tx_act = 1'b0;
          lk_nxt.tx_req[lk.tx_sel] = !lk.tx_req[lk.tx_sel];
        end
      end
    end
    // Polled TxClav: room, withdrawn near the end of a cell
    lk_nxt.tx_clav_oe = tx_pa[1];
    lk_nxt.tx_clav = tx_pa[1] && !tx_full[tx_pa[0]] &&
      !(lk.tx_act && lk.tx_sel == tx_pa[0] &&
        lk.tx_cnt >= DROP);
    // Receive select and byte delivery
    lk_nxt.rx_oe = 1'b0;
    if (rx_enb_n) begin
      lk_nxt.rx_selv = rx_pa[1];
      lk_nxt.rx_sel = rx_pa[0];
    end else if (lk.rx_selv) begin
      // Byte presented for capture in the next cycle
      if (!lk.rx_act && rx_rdy[lk.rx_sel]) begin
        lk_nxt.rx_act = 1'b1;
        lk_nxt.rx_cnt = 6'h01;
        lk_nxt.rx_soc = 1'b1;
        lk_nxt.rx_oe = 1'b1;
        lk_nxt.rx_data = rx_mem[lk.rx_sel][0];
      end else if (lk.rx_act) begin
        lk_nxt.rx_cnt = lk.rx_cnt + 6'h01;
        lk_nxt.rx_soc = 1'b0;
        lk_nxt.rx_oe = 1'b1;
        lk_nxt.rx_data = rx_mem[lk.rx_sel][lk.rx_cnt];
        // Last byte frees the slot
        if (lk.rx_cnt == LAST) begin
          lk_nxt.rx_act = 1'b0;
          lk_nxt.rx_ack[lk.rx_sel] = !lk.rx_ack[lk.rx_sel];
        end
      end
    end
    // Polled RxClav: complete cell held for that path
    lk_nxt.rx_clav_oe = rx_pa[1];
    lk_nxt.rx_clav = rx_pa[1] && rx_rdy[rx_pa[0]];
    // Remote end: one-cycle low reference pulse
    lk_nxt.rx_ref_n = OFFICE_END ||
      !(lk.ref_s1 ^ lk.ref_d);
    if (lk_rst) begin
      lk_nxt = '0;
      lk_nxt.rx_ref_n = 1'b1;
    end
    // Reset release crosses in two stages
    lk_nxt.rst_s = {lk.rst_s[0], rst_n};
  end

  // Link register; runs even in reset to clear itself
  always_ff @(posedge link_clk) begin
    lk <= lk_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // Core domain
  //////////////////////////////////////////////////////////////////////

  // Next core state
  always_comb begin
    logic push, pop, pick;
    ucp_cell_byte_t pe;
    sy_nxt = sy;
    push = 1'b0;
    pick = 1'b0;
    rx_we = 1'b0;
    rx_wp = cell_in.path;
    rx_wa = sy.wcnt[cell_in.path];
    pe = '{path: sy.drn_p, soc: sy.rd_cnt == '0,
           data: tx_mem[sy.drn_p][sy.rd_cnt]};
    pop = sy.ovld && cell_out_ready;
    // Crossing stages
    sy_nxt.tx_req_s0 = lk.tx_req;
    sy_nxt.tx_req_s1 = sy.tx_req_s0;
    sy_nxt.rx_ack_s0 = lk.rx_ack;
    sy_nxt.rx_ack_s1 = sy.rx_ack_s0;
    sy_nxt.tref_s0 = tx_ref_n;
    sy_nxt.tref_s1 = sy.tref_s0;
    sy_nxt.tref_d = sy.tref_s1;
    // Drain a full transmit cell, alternating paths
    case (sy.drn)
      UCP_DRN_IDLE: begin
        if ((sy.tx_req_s1 ^ sy.tx_ack) != 2'b00) begin
          pick = !sy.drn_p;
          if ((sy.tx_req_s1[pick] ^ sy.tx_ack[pick]) == 1'b0) begin
            pick = sy.drn_p;
          end
          sy_nxt.drn_p = pick;
          sy_nxt.rd_cnt = '0;
          sy_nxt.drn = UCP_DRN_MOVE;
        end
      end
      UCP_DRN_MOVE: begin
        // Stalls while the buffer holds two words and none is popped
        if (sy.bcnt != 2'd2 || pop) begin
          push = 1'b1;
          sy_nxt.rd_cnt = sy.rd_cnt + 6'h01;
          if (sy.rd_cnt == LAST) begin
            sy_nxt.tx_ack[sy.drn_p] = !sy.tx_ack[sy.drn_p];
            sy_nxt.drn = UCP_DRN_IDLE;
          end
        end
      end
      default: begin
        sy_nxt.drn = UCP_DRN_IDLE;
      end
    endcase
    // Two-entry buffer toward the core
    if (pop && push) begin
      if (sy.bcnt == 2'd1) begin
        sy_nxt.b0 = pe;
      end else begin
        sy_nxt.b0 = sy.b1;
        sy_nxt.b1 = pe;
      end
    end else if (pop) begin
      sy_nxt.b0 = sy.b1;
      sy_nxt.bcnt = sy.bcnt - 2'd1;
    end else if (push) begin
      if (sy.bcnt == 2'd0) begin
        sy_nxt.b0 = pe;
      end else begin
        sy_nxt.b1 = pe;
      end
      sy_nxt.bcnt = sy.bcnt + 2'd1;
    end
    sy_nxt.ovld = sy_nxt.bcnt != 2'd0;
    // Fill a receive cell; start mark realigns the count
    if (cell_in_valid && sy.in_rdy[cell_in.path]) begin
      rx_we = 1'b1;
      if (cell_in.soc) begin
        rx_wa = '0;
      end
      sy_nxt.wcnt[cell_in.path] = rx_wa + 6'h01;
      if (rx_wa == LAST) begin
        sy_nxt.wcnt[cell_in.path] = '0;
        sy_nxt.rx_req[cell_in.path] = !sy.rx_req[cell_in.path];
      end
    end
    // Slot free once the link has returned it
    sy_nxt.in_rdy = ~(sy_nxt.rx_req ^ sy.rx_ack_s1);
    // Reference: toggle toward the link always, pulse out to the core at the office end only
    if (net_ref_in) begin
      sy_nxt.ref_tgl = !sy.ref_tgl;
    end
    sy_nxt.ref_out = OFFICE_END && sy.tref_d && !sy.tref_s1;
  end

  // Core register, frozen while the enable is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sy <= SY_RST;
    end else if (ce) begin
      sy <= sy_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Cell stores
  //////////////////////////////////////////////////////////////////////

  // Transmit store, one writer on the link clock
  always_ff @(posedge link_clk) begin
    if (tx_we) begin
      tx_mem[tx_wp][tx_wa] <= tx_data;
    end
  end

  // Receive store, one writer on the core clock, frozen with the enable
  always_ff @(posedge sys_clk) begin
    if (ce && rx_we) begin
      rx_mem[rx_wp][rx_wa] <= cell_in.data;
    end
  end

  // One handshake check per path
  for (genvar p = 0; p < 2; p++) begin : g_path
    // Core acknowledges only a cell the link handed over
    a_tx_ack_full:
    assert property (@(posedge sys_clk) disable iff (!rst_n)
      sy.tx_ack[p] != $past(sy.tx_ack[p]) |->
      $past(sy.tx_req_s1[p] != sy.tx_ack[p]))
      else $error("transmit ack without full cell");
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs
  //////////////////////////////////////////////////////////////////////

  assign tx_clav = lk.tx_clav;
  assign tx_clav_oe = lk.tx_clav_oe;
  assign rx_clav = lk.rx_clav;
  assign rx_clav_oe = lk.rx_clav_oe;
  assign rx_soc = lk.rx_soc;
  assign rx_data = lk.rx_data;
  assign rx_oe = lk.rx_oe;
  assign rx_ref_n = lk.rx_ref_n;
  assign cell_out = sy.b0;
  assign cell_out_valid = sy.ovld;
  assign cell_in_ready = sy.in_rdy;
  assign net_ref_out = sy.ref_out;

  //////////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////////

  a_tx_clav_lead:
  assert property (@(posedge link_clk) disable iff (lk_rst)
    lk.tx_act && lk.tx_cnt >= DROP && tx_pa == {1'b1, lk.tx_sel}
    |=> !tx_clav)
    else $error("TxClav not withdrawn near cell end");

  a_tx_soc_take:
  assert property (@(posedge link_clk) disable iff (lk_rst)
    !tx_enb_n && tx_soc && lk.tx_selv && !tx_full[lk.tx_sel]
    |=> lk.tx_act && lk.tx_cnt == 6'h01)
    else $error("start byte not taken");

  a_tx_cell_hand:
  assert property (@(posedge link_clk) disable iff (lk_rst)
    !tx_enb_n && lk.tx_selv && lk.tx_act && !tx_soc &&
    lk.tx_cnt == LAST |=> !lk.tx_act ##0 $changed(lk.tx_req))
    else $error("cell not handed over after last byte");

  a_tx_clav_addr:
  assert property (@(posedge link_clk) disable iff (lk_rst)
    !tx_pa[1] |=> !tx_clav_oe && !tx_clav)
    else $error("TxClav driven for foreign address");

  a_rx_soc_first:
  assert property (@(posedge link_clk) disable iff (lk_rst)
    !rx_enb_n && lk.rx_selv && !lk.rx_act && rx_rdy[lk.rx_sel]
    |=> rx_soc && rx_oe && lk.rx_cnt == 6'h01)
    else $error("first receive byte lacks start mark");

  a_rx_next_byte:
  assert property (@(posedge link_clk) disable iff (lk_rst)
    !rx_enb_n && lk.rx_selv && lk.rx_act
    |=> rx_oe && !rx_soc &&
        lk.rx_cnt == $past(lk.rx_cnt) + 6'h01)
    else $error("receive byte not presented next cycle");

  a_rx_clav_drop:
  assert property (@(posedge link_clk) disable iff (lk_rst)
    !rx_enb_n && lk.rx_selv && lk.rx_act &&
    lk.rx_cnt == LAST && rx_pa == {1'b1, lk.rx_sel}
    ##1 $stable(rx_addr) |=> !rx_clav)
    else $error("RxClav held after cell end");

  a_ref_pulse:
  assert property (@(posedge link_clk) disable iff (lk_rst)
    !rx_ref_n |=> rx_ref_n)
    else $error("reference pulse longer than one cycle");

  a_buf_hold:
  assert property (@(posedge sys_clk) disable iff (!rst_n)
    cell_out_valid && !cell_out_ready
    |=> cell_out_valid && $stable(cell_out))
    else $error("buffered word lost under stall");

  c_tx_cell:
  cover property (@(posedge link_clk) disable iff (lk_rst)
    lk.tx_act && lk.tx_cnt == LAST && !tx_enb_n);
  c_rx_cell:
  cover property (@(posedge link_clk) disable iff (lk_rst)
    lk.rx_act && lk.rx_cnt == LAST && !rx_enb_n);
  c_buf_full:
  cover property (@(posedge sys_clk) disable iff (!rst_n)
    sy.bcnt == 2'd2);
  c_both_paths:
  cover property (@(posedge sys_clk) disable iff (!rst_n)
    sy.tx_req_s1 != sy.tx_ack && (sy.tx_req_s1 ^ sy.tx_ack) == 2'b11);
endmodule
`default_nettype wire

// ---- dv/ucp_atm_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ucp_atm_model (
  // Link clock
  output logic link_clk,
  // Transmit side
  output logic tx_enb_n,
  output logic tx_soc,
  output ucp_pkg::ucp_byte_t tx_data,
  output logic [4:0] tx_addr,
  output logic tx_ref_n,
  input wire logic tx_clav,
  // Receive side
  output logic rx_enb_n,
  output logic [4:0] rx_addr,
  input wire logic rx_clav,
  input wire logic rx_soc,
  input wire ucp_pkg::ucp_byte_t rx_data,
  input wire logic rx_oe
);
  import ucp_pkg::*;
  //////////////////////////////////////////
  // Free-running clock, phase offset from core
  initial begin
    link_clk = 1'b0;
    {tx_enb_n, tx_soc, tx_ref_n, rx_enb_n} = 4'hb;
    tx_data = 8'h00;
    tx_addr = 5'h1f;
    rx_addr = 5'h1f;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // Select one port for both directions
  task automatic set_addr(input logic [4:0] a);
    @(posedge link_clk);
    tx_addr <= a;
    rx_addr <= a;
    repeat (3) @(posedge link_clk);
  endtask
  // Poll, then one whole cell back to back
  task automatic send_cell(input logic [4:0] a, input ucp_byte_t b,
    output int hi, output bit ok);
    int n;
    hi = 0;
    ok = 1'b0;
    set_addr(a);
    for (n = 0; n < 40 && !ok; n++) begin
      @(posedge link_clk);
      ok = tx_clav === 1'b1;
    end
    for (n = 0; ok && n < 54; n++) begin
      @(posedge link_clk);
      // Clav seen at the edge taking byte n-1
      if (n > 0 && tx_clav === 1'b1) hi++;
      tx_enb_n <= n == 53;
      tx_soc <= n == 0;
      // Released bus shows the inverse, not a stale byte
      tx_data <= n == 53 ? ~tx_data : b + 8'(n);
    end
  endtask
  // Poll, take one cell; good counts bytes plus the Clav drop
  task automatic recv_cell(input logic [4:0] a, input ucp_byte_t b,
    output int good, output bit ok);
    int n;
    good = 0;
    ok = 1'b0;
    set_addr(a);
    for (n = 0; n < 400 && !ok; n++) begin
      @(posedge link_clk);
      ok = rx_clav === 1'b1;
    end
    for (n = 0; ok && n < 58; n++) begin
      @(posedge link_clk);
      // Byte requested at edge n-1 is captured here
      if (n > 1 && n < 55 && rx_oe === 1'b1 && rx_soc === (n == 2) &&
          rx_data === b + 8'(n - 2)) good++;
      if (n == 57 && rx_clav === 1'b0) good++;
      rx_enb_n <= n > 52;
    end
  endtask
  // One link-cycle reference pulse
  task automatic pulse_ref();
    @(posedge link_clk);
    tx_ref_n <= 1'b0;
    @(posedge link_clk);
    tx_ref_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ucp_defines.svh"
module testbench;
  import ucp_pkg::*;
  //////////////////////////////////////////
  // Core side drive
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic cell_out_ready = 1'b0;
  logic cell_in_valid = 1'b0;
  logic net_ref_in = 1'b0;
  ucp_cell_byte_t cell_in = '0;
  // Link wires and design outputs
  logic link_clk, tx_enb_n, tx_soc, tx_ref_n, tx_clav, tx_clav_oe;
  logic rx_enb_n, rx_clav, rx_clav_oe, rx_soc, rx_oe, rx_ref_n;
  logic cell_out_valid, net_ref_out;
  logic rx_ref_n_rem, net_ref_out_rem; // Remote-end copy outputs
  logic [4:0] tx_addr, rx_addr;
  logic [1:0] cell_in_ready;
  ucp_byte_t tx_data, rx_data;
  ucp_cell_byte_t cell_out;
  // Score and scratch
  int fail_count = 0;
  int tests_run = 0;
  int hi, good;
  bit ok;
  // Core clock, 50 MHz
  always #10 sys_clk = ~sys_clk;
  ucp_phy_port u_ucp_phy_port (.sys_clk, .rst_n, .ce, .link_clk,
    .tx_enb_n, .tx_soc, .tx_data, .tx_addr, .tx_ref_n, .tx_clav,
    .tx_clav_oe, .rx_enb_n, .rx_addr, .rx_clav, .rx_clav_oe, .rx_soc,
    .rx_data, .rx_oe, .rx_ref_n, .cell_out, .cell_out_valid,
    .cell_out_ready, .cell_in, .cell_in_valid, .cell_in_ready,
    .net_ref_in, .net_ref_out);
  // Remote-end copy on the same pins; only its references are watched
  if (1) begin : g_remote
    ucp_phy_port #(.OFFICE_END(1'b0)) u_ucp_phy_port (.sys_clk, .rst_n,
      .ce, .link_clk, .tx_enb_n, .tx_soc, .tx_data, .tx_addr, .tx_ref_n,
      .tx_clav(), .tx_clav_oe(), .rx_enb_n, .rx_addr, .rx_clav(),
      .rx_clav_oe(), .rx_soc(), .rx_data(), .rx_oe(),
      .rx_ref_n(rx_ref_n_rem), .cell_out(), .cell_out_valid(),
      .cell_out_ready, .cell_in, .cell_in_valid, .cell_in_ready(),
      .net_ref_in, .net_ref_out(net_ref_out_rem));
  end
  ucp_atm_model u_ucp_atm_model (.link_clk, .tx_enb_n, .tx_soc,
    .tx_data, .tx_addr, .tx_ref_n, .tx_clav, .rx_enb_n, .rx_addr,
    .rx_clav, .rx_soc, .rx_data, .rx_oe);
  //////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // A bound ran out: nothing later can be trusted
  task automatic need(input bit c);
    check(c, 1);
    if (!c) final_report();
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Drain one cell, stalled first so the buffer fills
  task automatic pop_cell(input logic p, input ucp_byte_t b);
    int i;
    i = 0;
    for (int k = 0; k < 3000 && i < 53; k++) begin
      @(posedge sys_clk);
      if (ce && cell_out_ready && cell_out_valid === 1'b1) begin
        check(cell_out, {p, i == 0, 8'(b + i)});
        i++;
      end
      // Core frozen mid-cell: no byte may be lost or repeated
      ce <= !(k > 24 && k < 30);
      cell_out_ready <= i < 53 && k > 20 && k[0];
    end
    need(i == 53);
  endtask
  // Load one cell on a path
  task automatic push_cell(input logic p, input ucp_byte_t b);
    int i;
    i = 0;
    @(posedge sys_clk);
    cell_in_valid <= 1'b1;
    cell_in <= {p, 1'b1, b};
    for (int k = 0; k < 500 && i < 53; k++) begin
      @(posedge sys_clk);
      if (cell_in_ready[p] === 1'b1) begin
        i++;
        cell_in <= {p, 1'b0, 8'(b + i)};
      end
    end
    cell_in_valid <= 1'b0;
    need(i == 53);
    repeat (2) @(posedge sys_clk);
    check(cell_in_ready[p], 1'b0);
  endtask
  //////////////////////////////////////////
  // Foreign address is ignored, own address answers
  task automatic test_addr();
    u_ucp_atm_model.set_addr(5'h02);
    @(posedge sys_clk);
    check({tx_clav_oe, rx_clav_oe}, 2'b00);
    u_ucp_atm_model.set_addr(5'h01);
    @(posedge sys_clk);
    check({tx_clav_oe, tx_clav, rx_clav_oe, rx_clav}, 4'he);
    $display("test_addr done");
  endtask
  // One cell into each path, out at the core
  task automatic test_tx();
    for (int p = 0; p < 2; p++) begin
      u_ucp_atm_model.send_cell(5'(p), 8'(16 * p + 3), hi, ok);
      need(ok);
      check(hi, `UCP_CELL_BYTES - `UCP_CLAV_LEAD + 1);
      pop_cell(p[0], 8'(16 * p + 3));
    end
    $display("test_tx done");
  endtask
  // Both paths loaded, slow drained before fast
  task automatic test_rx();
    push_cell(1'b0, 8'h40);
    push_cell(1'b1, 8'h80);
    for (int p = 1; p >= 0; p--) begin
      u_ucp_atm_model.recv_cell(5'(p), 8'(64 * (p + 1)), good, ok);
      need(ok);
      check(good, 54);
    end
    $display("test_rx done");
  endtask
  // Office copy passes the reference in, remote copy drives it out
  task automatic test_ref();
    int n, r, f, z;
    logic prv;
    n = 0;
    r = 0;
    f = 0;
    z = 0;
    prv = 1'b1;
    fork
      u_ucp_atm_model.pulse_ref();
    join_none
    for (int k = 0; k < 30; k++) begin
      @(posedge sys_clk);
      net_ref_in <= k == 0;
      n += net_ref_out === 1'b1;
      r += rx_ref_n !== 1'b1;
      f += prv === 1'b1 && rx_ref_n_rem === 1'b0;
      z += net_ref_out_rem !== 1'b0;
      prv = rx_ref_n_rem;
    end
    check(n, 1);
    check(r, 0);
    check(f, 1);
    check(z, 0);
    $display("test_ref done");
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    check({tx_clav_oe, rx_clav_oe, rx_oe, cell_out_valid, rx_ref_n}, 5'h01);
    repeat (12) @(posedge sys_clk);
    test_addr();
    test_tx();
    test_rx();
    test_ref();
    final_report();
  end
endmodule
`default_nettype wire
